// >>> line_stride_regs.sv
// Register block and AXI4-Lite slave for the LCD and CRT/TV line strides.
`timescale 1ns/100ps
module line_stride_regs
    import line_stride_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                lcd_frame_start,
    input  wire logic                lcd_line_start,
    input  wire logic                tv_frame_start,
    input  wire logic                tv_line_start,
    output logic [WADDR_W-1:0]       lcd_line_addr,
    output logic [WADDR_W-1:0]       tv_line_addr,
    output logic [BYTES_W-1:0]       lcd_line_bytes,
    output logic [BYTES_W-1:0]       tv_line_bytes,
    output logic [PPW_W-1:0]         lcd_pixels_in_each_word,
    output logic [PPW_W-1:0]         tv_pixels_in_each_word
);

    typedef struct packed
    {
        logic [STRIDE_W-1:0] lcd_stride;
        logic [STRIDE_W-1:0] tv_stride;
        logic [WADDR_W-1:0]  lcd_start;
        logic [WADDR_W-1:0]  tv_start;
        logic [1:0]          lcd_depth;
        logic [1:0]          tv_depth;
        logic                aw_got;
        logic                w_got;
        logic [AXI_AW-1:0]   aw_addr;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        logic [PPW_W-1:0]    lcd_ppw;
        logic [PPW_W-1:0]    tv_ppw;
    } regs_state_t;

    regs_state_t st;
    regs_state_t next_st;

    // Index 0 is the LCD path, index 1 the CRT/TV path.
    line_if chan [2] ();

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_path
            line_addr_gen u_gen
            (
                .aclk    (aclk),
                .aresetn (aresetn),
                .lk      (chan[g].gen)
            );
        end
    endgenerate

    assign chan[0].stride      = st.lcd_stride;
    assign chan[1].stride      = st.tv_stride;
    assign chan[0].start       = st.lcd_start;
    assign chan[1].start       = st.tv_start;
    assign chan[0].frame_start = lcd_frame_start;
    assign chan[0].line_start  = lcd_line_start;
    assign chan[1].frame_start = tv_frame_start;
    assign chan[1].line_start  = tv_line_start;

    // Pixels in each word is sixteen over the depth; 15 bpp takes a whole word.
    function automatic logic [PPW_W-1:0] depth_ppw(input logic [1:0] d);
        case (depth_t'(d))
            DEPTH_4BPP:  depth_ppw = 5'h04;
            DEPTH_8BPP:  depth_ppw = 5'h02;
            default:     depth_ppw = 5'h01;
        endcase
    endfunction

    // Virtual line pixel count read back for the host.
    function automatic logic [PIXCNT_W-1:0] vpix(input logic [STRIDE_W-1:0] s,
                                                 input logic [1:0] d);
        logic [EFF_W+PPW_W-1:0] p;
        p = eff_stride(s) * depth_ppw(d);
        vpix = p[PIXCNT_W-1:0];
    endfunction

    // Byte address of a printed index.
    function automatic logic [AXI_AW-1:0] reg_addr(input logic [AXI_AW-1:0] idx);
        reg_addr = {idx[AXI_AW-3:0], 2'b00};
    endfunction

    function automatic logic [31:0] read_word(input regs_state_t s,
                                              input logic [AXI_AW-1:0] a,
                                              input logic [WADDR_W-1:0] la,
                                              input logic [WADDR_W-1:0] ta,
                                              output logic hit);
        read_word = 32'h0000_0000;
        hit = 1'b1;
        if (a == reg_addr(IDX_LCD_STRIDE_LOW))
            read_word[7:0] = s.lcd_stride[7:0];
        else if (a == reg_addr(IDX_LCD_STRIDE_HIGH))
            read_word[2:0] = s.lcd_stride[10:8];
        else if (a == reg_addr(IDX_TV_STRIDE_LOW))
            read_word[7:0] = s.tv_stride[7:0];
        else if (a == reg_addr(IDX_TV_STRIDE_HIGH))
            read_word[2:0] = s.tv_stride[10:8];
        else if (a == ADDR_LCD_START)
            read_word[WADDR_W-1:0] = s.lcd_start;
        else if (a == ADDR_TV_START)
            read_word[WADDR_W-1:0] = s.tv_start;
        else if (a == ADDR_DEPTH)
        begin
            read_word[DEPTH_LCD_LSB +: 2] = s.lcd_depth;
            read_word[DEPTH_TV_LSB +: 2]  = s.tv_depth;
        end
        else if (a == ADDR_LCD_LINE)
            read_word[WADDR_W-1:0] = la;
        else if (a == ADDR_TV_LINE)
            read_word[WADDR_W-1:0] = ta;
        else if (a == ADDR_LCD_VPIX)
            read_word[PIXCNT_W-1:0] = vpix(s.lcd_stride, s.lcd_depth);
        else if (a == ADDR_TV_VPIX)
            read_word[PIXCNT_W-1:0] = vpix(s.tv_stride, s.tv_depth);
        else
            hit = 1'b0;
    endfunction

    always_comb
    begin
        logic        rd_hit;
        logic        wr_hit;
        logic [31:0] rd_word;
        logic [7:0]  b0;
        logic [31:0] wd;
        rd_hit  = 1'b0;
        wr_hit  = 1'b0;
        rd_word = 32'h0000_0000;
        b0      = 8'h00;
        wd      = 32'h0000_0000;
        next_st = st;

        // Address and data may arrive in either order; each is held until both are in.
        if (st.awready && s_axi_awvalid)
        begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (st.wready && s_axi_wvalid)
        begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            b0     = st.w_strb[0] ? st.w_data[7:0] : 8'h00;
            wd     = st.w_data;
            wr_hit = 1'b1;
            if (st.aw_addr == reg_addr(IDX_LCD_STRIDE_LOW))
            begin
                if (st.w_strb[0])
                    next_st.lcd_stride[7:0] = b0;
            end
            else if (st.aw_addr == reg_addr(IDX_LCD_STRIDE_HIGH))
            begin
                if (st.w_strb[0])
                    next_st.lcd_stride[10:8] = b0[2:0];
            end
            else if (st.aw_addr == reg_addr(IDX_TV_STRIDE_LOW))
            begin
                if (st.w_strb[0])
                    next_st.tv_stride[7:0] = b0;
            end
            else if (st.aw_addr == reg_addr(IDX_TV_STRIDE_HIGH))
            begin
                if (st.w_strb[0])
                    next_st.tv_stride[10:8] = b0[2:0];
            end
            else if (st.aw_addr == ADDR_LCD_START)
            begin
                for (int i = 0; i < 3; i++)
                    if (st.w_strb[i])
                        next_st.lcd_start[i*8 +: 4] = wd[i*8 +: 4];
                for (int i = 0; i < 2; i++)
                    if (st.w_strb[i])
                        next_st.lcd_start[i*8+4 +: 4] = wd[i*8+4 +: 4];
            end
            else if (st.aw_addr == ADDR_TV_START)
            begin
                for (int i = 0; i < 3; i++)
                    if (st.w_strb[i])
                        next_st.tv_start[i*8 +: 4] = wd[i*8 +: 4];
                for (int i = 0; i < 2; i++)
                    if (st.w_strb[i])
                        next_st.tv_start[i*8+4 +: 4] = wd[i*8+4 +: 4];
            end
            else if (st.aw_addr == ADDR_DEPTH)
            begin
                if (st.w_strb[0])
                begin
                    next_st.lcd_depth = wd[DEPTH_LCD_LSB +: 2];
                    next_st.tv_depth  = wd[DEPTH_TV_LSB +: 2];
                end
            end
            else if (st.aw_addr == ADDR_LCD_LINE || st.aw_addr == ADDR_TV_LINE
                     || st.aw_addr == ADDR_LCD_VPIX || st.aw_addr == ADDR_TV_VPIX)
            begin
                // Status words ignore writes but still answer OKAY.
                wr_hit = 1'b1;
            end
            else
            begin
                wr_hit = 1'b0;
            end
            next_st.bvalid = 1'b1;
            next_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
        end

        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;

        if (st.arready && s_axi_arvalid)
        begin
            rd_word = read_word(st, s_axi_araddr, chan[0].line_addr,
                                chan[1].line_addr, rd_hit);
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_word;
            next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // Readies are registered so that every bus output comes from a flop.
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;

        // Depth changes do not rescale the stride; software must rewrite it.
        next_st.lcd_ppw = depth_ppw(next_st.lcd_depth);
        next_st.tv_ppw  = depth_ppw(next_st.tv_depth);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st            <= '0;
            st.lcd_stride <= RST_STRIDE;
            st.tv_stride  <= RST_STRIDE;
            st.lcd_start  <= RST_START;
            st.tv_start   <= RST_START;
            st.lcd_depth  <= RST_DEPTH;
            st.tv_depth   <= RST_DEPTH;
            st.bresp      <= RESP_OKAY;
            st.rresp      <= RESP_OKAY;
            st.lcd_ppw    <= 5'h01;
            st.tv_ppw     <= 5'h01;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign s_axi_awready           = st.awready;
    assign s_axi_wready            = st.wready;
    assign s_axi_bvalid            = st.bvalid;
    assign s_axi_bresp             = st.bresp;
    assign s_axi_arready           = st.arready;
    assign s_axi_rvalid            = st.rvalid;
    assign s_axi_rresp             = st.rresp;
    assign s_axi_rdata             = st.rdata;
    assign lcd_pixels_in_each_word = st.lcd_ppw;
    assign tv_pixels_in_each_word  = st.tv_ppw;
    assign lcd_line_addr           = chan[0].line_addr;
    assign tv_line_addr            = chan[1].line_addr;
    assign lcd_line_bytes          = chan[0].line_bytes;
    assign tv_line_bytes           = chan[1].line_bytes;

endmodule // line_stride_regs

// >>> line_stride_pkg.sv
// Shared constants, register map and helpers for the line stride logic.
package line_stride_pkg;

    localparam int STRIDE_W = 11;
    localparam int EFF_W    = 12;
    localparam int WADDR_W  = 20;
    localparam int BYTES_W  = 13;
    localparam int PIXCNT_W = 15;
    localparam int PPW_W    = 5;
    localparam int AXI_AW   = 12;

    // Printed register indices; the byte address is four times the index.
    localparam logic [AXI_AW-1:0] IDX_LCD_STRIDE_LOW  = 12'h046;
    localparam logic [AXI_AW-1:0] IDX_LCD_STRIDE_HIGH = 12'h047;
    localparam logic [AXI_AW-1:0] IDX_TV_STRIDE_LOW   = 12'h066;
    localparam logic [AXI_AW-1:0] IDX_TV_STRIDE_HIGH  = 12'h067;

    // Byte addresses of the added control and status words.
    localparam logic [AXI_AW-1:0] ADDR_LCD_START  = 12'h200;
    localparam logic [AXI_AW-1:0] ADDR_TV_START   = 12'h204;
    localparam logic [AXI_AW-1:0] ADDR_DEPTH      = 12'h208;
    localparam logic [AXI_AW-1:0] ADDR_LCD_LINE   = 12'h20C;
    localparam logic [AXI_AW-1:0] ADDR_TV_LINE    = 12'h210;
    localparam logic [AXI_AW-1:0] ADDR_LCD_VPIX   = 12'h214;
    localparam logic [AXI_AW-1:0] ADDR_TV_VPIX    = 12'h218;

    // Field positions inside the depth word.
    localparam int DEPTH_LCD_LSB = 0;
    localparam int DEPTH_TV_LSB  = 2;

    // Reset values.
    localparam logic [STRIDE_W-1:0] RST_STRIDE = 11'h000;
    localparam logic [WADDR_W-1:0]  RST_START  = 20'h00000;
    localparam logic [1:0]          RST_DEPTH  = 2'h2;

    // Largest stride in words; a zero field stands for it.
    localparam logic [EFF_W-1:0] STRIDE_MAX = 12'h800;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        DEPTH_4BPP  = 2'b00,
        DEPTH_8BPP  = 2'b01,
        DEPTH_16BPP = 2'b10,
        DEPTH_15BPP = 2'b11
    } depth_t;

    // Eleven bit field to stride in words.
    function automatic logic [EFF_W-1:0] eff_stride(input logic [STRIDE_W-1:0] f);
        eff_stride = (f == '0) ? STRIDE_MAX : {1'b0, f};
    endfunction

endpackage

// >>> line_if.sv
// Connection between the register block and one line address generator.
`timescale 1ns/100ps
interface line_if;
    import line_stride_pkg::*;
    logic [STRIDE_W-1:0] stride;
    logic [WADDR_W-1:0]  start;
    logic                frame_start;
    logic                line_start;
    logic [WADDR_W-1:0]  line_addr;
    logic [BYTES_W-1:0]  line_bytes;

    modport gen (input stride, start, frame_start, line_start,
                 output line_addr, line_bytes);
    modport ctl (output stride, start, frame_start, line_start,
                 input line_addr, line_bytes);
endinterface

// >>> line_addr_gen.sv
// Per-path line start address generator for the refresh fetch.
`timescale 1ns/100ps
module line_addr_gen
    import line_stride_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    line_if.gen       lk
);

    typedef struct packed
    {
        logic [WADDR_W-1:0] line_addr;
        logic [BYTES_W-1:0] line_bytes;
    } gen_state_t;

    gen_state_t st;
    gen_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.line_bytes = {lk.stride == '0, lk.stride, 1'b0};
        if (lk.frame_start)
        begin
            // The start address is only taken here, so a change mid-frame cannot tear.
            next_st.line_addr = lk.start;
        end
        else if (lk.line_start)
        begin
            next_st.line_addr = st.line_addr
                + WADDR_W'(eff_stride(lk.stride));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign lk.line_addr  = st.line_addr;
    assign lk.line_bytes = st.line_bytes;

endmodule // line_addr_gen

// >>> line_stride_regs_asserts.sv
// Port checks for the line stride register block.
`timescale 1ns/100ps
module line_stride_regs_asserts
    import line_stride_pkg::*;
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               lcd_frame_start,
    input wire logic               lcd_line_start,
    input wire logic               tv_frame_start,
    input wire logic               tv_line_start,
    input wire logic [WADDR_W-1:0] lcd_line_addr,
    input wire logic [WADDR_W-1:0] tv_line_addr,
    input wire logic [BYTES_W-1:0] lcd_line_bytes,
    input wire logic [BYTES_W-1:0] tv_line_bytes,
    input wire logic [PPW_W-1:0]   lcd_pixels_in_each_word
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        (!s_axi_awready && !s_axi_bvalid) ##1 s_axi_bvalid;
    endsequence
    a_write_answer: assert property (wr_taken |=> wr_answer)
        else $error("write answer out of place");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer not at once");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    // A write lands one edge before the byte count follows it, so that cycle is left out.
    a_lcd_step: assert property (lcd_line_start && !lcd_frame_start && !s_axi_bvalid
        && lcd_line_bytes != '0 |=> lcd_line_addr == $past(lcd_line_addr)
        + WADDR_W'($past(lcd_line_bytes) >> 1)) else $error("lcd line step wrong");
    a_tv_step: assert property (tv_line_start && !tv_frame_start && !s_axi_bvalid
        && tv_line_bytes != '0 |=> tv_line_addr == $past(tv_line_addr)
        + WADDR_W'($past(tv_line_bytes) >> 1)) else $error("tv line step wrong");
    a_lcd_hold: assert property (!lcd_frame_start && !lcd_line_start
        |=> $stable(lcd_line_addr)) else $error("lcd line address moved");
    a_tv_hold: assert property (!tv_frame_start && !tv_line_start
        |=> $stable(tv_line_addr)) else $error("tv line address moved");
    a_bytes_span: assert property (lcd_line_bytes <= 13'h1000 && !lcd_line_bytes[0])
        else $error("line bytes out of range");
    a_word_pixels: assert property (lcd_pixels_in_each_word inside {5'h01, 5'h02, 5'h04})
        else $error("pixels per word not a legal count");
endmodule // line_stride_regs_asserts

bind line_stride_regs line_stride_regs_asserts i_line_stride_regs_asserts (.*);

// >>> axil_host_model.sv
// Host model that programs the stride registers over AXI4-Lite.
`timescale 1ns/100ps
module axil_host_model
    import line_stride_pkg::*;
(
    input  wire logic              aclk,
    output logic [AXI_AW-1:0]      s_axi_awaddr,
    output logic                   s_axi_awvalid,
    input  wire logic              s_axi_awready,
    output logic [31:0]            s_axi_wdata,
    output logic [3:0]             s_axi_wstrb,
    output logic                   s_axi_wvalid,
    input  wire logic              s_axi_wready,
    input  wire logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_bvalid,
    output logic                   s_axi_bready,
    output logic [AXI_AW-1:0]      s_axi_araddr,
    output logic                   s_axi_arvalid,
    input  wire logic              s_axi_arready,
    input  wire logic [31:0]       s_axi_rdata,
    input  wire logic [1:0]        s_axi_rresp,
    input  wire logic              s_axi_rvalid,
    output logic                   s_axi_rready
);
    // A slow host raises its answer ready late, so the slave has to hold its answer.
    bit slow = 1'b0;
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] st, output logic [1:0] r, output bit ok);
        ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        for (int n = 1; n < 64 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                r = s_axi_bresp;
                ok = 1'b1;
                s_axi_bready <= 1'b0;
            end
            else if (n == 3)
                s_axi_bready <= 1'b1;
        end
    endtask
    task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                      output logic [1:0] r, output bit ok);
        ok = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        for (int n = 1; n < 64 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                ok = 1'b1;
                s_axi_rready <= 1'b0;
            end
            else if (n == 3)
                s_axi_rready <= 1'b1;
        end
    endtask
endmodule // axil_host_model

// >>> line_stride_regs_tb_top.sv
// Self-checking bench for the line stride register block.
`timescale 1ns/100ps
module line_stride_regs_tb_top import line_stride_pkg::*;;
    localparam logic [AXI_AW-1:0] A_LCD_LO = IDX_LCD_STRIDE_LOW << 2;
    localparam logic [AXI_AW-1:0] A_LCD_HI = IDX_LCD_STRIDE_HIGH << 2;
    localparam logic [AXI_AW-1:0] A_TV_LO  = IDX_TV_STRIDE_LOW << 2;
    localparam logic [AXI_AW-1:0] A_TV_HI  = IDX_TV_STRIDE_HIGH << 2;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, lcd_frame_start, lcd_line_start, tv_frame_start, tv_line_start;
    logic [AXI_AW-1:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]         s_axi_awprot, s_axi_arprot;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic [WADDR_W-1:0] lcd_line_addr, tv_line_addr;
    logic [BYTES_W-1:0] lcd_line_bytes, tv_line_bytes;
    logic [PPW_W-1:0]   lcd_pixels_in_each_word, tv_pixels_in_each_word;
    int                 n_mismatch = 0;
    int                 cmp_count = 0;
    line_stride_regs i_line_stride_regs (.*);
    axil_host_model i_axil_host_model (.*);
    always #2 aclk = ~aclk;
    task automatic close_out();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] st = 4'hF, input logic [1:0] er = RESP_OKAY);
        logic [1:0] r;
        bit         ok;
        i_axil_host_model.wr(a, d, st, r, ok);
        if (!ok)
        begin
            n_mismatch++;
            $display("[FAIL] %0t write answer timed out", $time);
            close_out();
        end
        else
            check(32'(r), 32'(er));
    endtask
    task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] want,
                      input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        bit          ok;
        i_axil_host_model.rd(a, d, r, ok);
        if (!ok)
        begin
            n_mismatch++;
            $display("[FAIL] %0t read answer timed out", $time);
            close_out();
        end
        else
        begin
            check(32'(r), 32'(er));
            check(d, want);
        end
    endtask
    task automatic pulse(input logic [3:0] which, input int n = 1);
        @(posedge aclk);
        {lcd_frame_start, lcd_line_start, tv_frame_start, tv_line_start} <= which;
        repeat (n) @(posedge aclk);
        {lcd_frame_start, lcd_line_start, tv_frame_start, tv_line_start} <= 4'h0;
        @(negedge aclk);
    endtask
    task automatic t_reset();
        check(32'(lcd_line_bytes), 32'h1000);
        check(32'(tv_line_bytes), 32'h1000);
        check(32'(lcd_pixels_in_each_word), 32'h1);
        rd(A_LCD_HI, 32'h0);
    endtask
    task automatic t_lcd();
        wr(A_LCD_LO, 32'h90);
        wr(A_LCD_HI, 32'hF9);
        rd(A_LCD_HI, 32'h01);
        rd(A_LCD_LO, 32'h90);
        wr(ADDR_LCD_START, 32'h12345);
        pulse(4'h8);
        check(32'(lcd_line_addr), 32'h12345);
        pulse(4'h4, 2);
        check(32'(lcd_line_addr), 32'h12665);
        check(32'(lcd_line_bytes), 32'h320);
        check(32'(tv_line_addr), 32'h0);
        pulse(4'hC);
        check(32'(lcd_line_addr), 32'h12345);
        wr(ADDR_LCD_START, 32'hABC);
        pulse(4'h4);
        check(32'(lcd_line_addr), 32'h124D5);
    endtask
    task automatic t_tv();
        i_axil_host_model.slow = 1'b1;
        wr(A_TV_LO, 32'hC8);
        wr(A_TV_HI, 32'hF8);
        rd(A_TV_HI, 32'h0);
        wr(ADDR_TV_START, 32'hFFF80);
        i_axil_host_model.slow = 1'b0;
        pulse(4'h2);
        pulse(4'h1);
        check(32'(tv_line_addr), 32'h48);
        check(32'(tv_line_bytes), 32'h190);
        check(32'(lcd_line_addr), 32'h124D5);
    endtask
    task automatic t_depth();
        logic [4:0] ppw [4] = '{5'h04, 5'h02, 5'h01, 5'h01};
        for (int d = 0; d < 4; d++)
        begin
            wr(ADDR_DEPTH, 32'(d) | (32'(3 - d) << 2));
            wr(A_LCD_LO, 32'((800 / ppw[d]) & 8'hFF));
            wr(A_LCD_HI, 32'((800 / ppw[d]) >> 8));
            check(32'(lcd_pixels_in_each_word), 32'(ppw[d]));
            check(32'(tv_pixels_in_each_word), 32'(ppw[3 - d]));
            rd(ADDR_LCD_VPIX, 32'h320);
        end
    endtask
    task automatic t_edge();
        wr(A_LCD_LO, 32'h0);
        wr(A_LCD_HI, 32'h0);
        wr(A_LCD_LO, 32'h55, 4'hE);
        check(32'(lcd_line_bytes), 32'h1000);
        rd(A_LCD_LO, 32'h0);
        pulse(4'h4);
        check(32'(lcd_line_addr), 32'h12CD5);
        rd(12'h100, 32'h0, RESP_SLVERR);
        wr(12'h104, 32'h1, 4'hF, RESP_SLVERR);
        wr(ADDR_LCD_LINE, 32'h0);
        rd(ADDR_LCD_LINE, 32'h12CD5);
    endtask
    initial
    begin
        aresetn = 1'b0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        {lcd_frame_start, lcd_line_start, tv_frame_start, tv_line_start} = 4'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        t_reset();
        t_lcd();
        t_tv();
        t_depth();
        t_edge();
        close_out();
    end
endmodule // line_stride_regs_tb_top
